// File: spf_cfg.svh
/*
 * Constants of the serial flash status and protection block: status
 * bit positions, reset values, opcodes, frame lengths and timing.
 * Assumes inclusion by bare name from spf_protect_decode and spf_status_protect.
 */
`ifndef SPF_CFG_SVH
`define SPF_CFG_SVH

// ----------------------------------------------------------------
// status bit positions
// ----------------------------------------------------------------
`define SPF_ST_BUSY      0
`define SPF_ST_WEL       1
`define SPF_ST_BP_LO     2
`define SPF_ST_BP_HI     4
`define SPF_ST_TB        5
`define SPF_ST_RSV       6
`define SPF_ST_LOCK      7

// ----------------------------------------------------------------
// reset values (factory defaults)
// ----------------------------------------------------------------
`define SPF_RST_BP       3'h0
`define SPF_RST_TB       1'h0
`define SPF_RST_LOCK     1'h0
`define SPF_RST_WEL      1'h0

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define SPF_OP_WREN      8'h06
`define SPF_OP_WRDI      8'h04
`define SPF_OP_RDSR      8'h05
`define SPF_OP_WRSR      8'h01
`define SPF_OP_PP        8'h02
`define SPF_OP_BE        8'hd8
`define SPF_OP_SE        8'h20
`define SPF_OP_CE_A      8'hc7
`define SPF_OP_CE_B      8'h60
`define SPF_OP_RDID8     8'hab
`define SPF_OP_MFDID     8'h90
`define SPF_OP_JID       8'h9f

// ----------------------------------------------------------------
// frame lengths in bytes, opcode included; SPF_LEN_JID counts the identification bytes only
// ----------------------------------------------------------------
`define SPF_LEN_CMD      3'h1
`define SPF_LEN_WRSR     3'h2
`define SPF_LEN_ADDR     3'h4
`define SPF_LEN_PP       3'h5
`define SPF_LEN_JID      3'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SPF_MCLK_MHZ     100
`define SPF_SRW_TIME_NS  10000
`define SPF_SRW_CYCLES   ((`SPF_SRW_TIME_NS * `SPF_MCLK_MHZ + 999) / 1000)

`endif

// File: spf_pkg.sv
/*
 * Types shared by the serial flash status and protection block.
 * Assumes spf_cfg.svh holds the numeric constants.
 */
package spf_pkg;

    // one-hot sequencer states
    typedef enum logic [2:0] {
        SPF_IDLE = 3'b001,
        SPF_SRW  = 3'b010,
        SPF_ARR  = 3'b100
    } spf_state_t;

    // density selector: 0 = 1 Mbit ... 3 = 8 Mbit
    typedef logic [1:0] spf_density_t;

endpackage

// File: spf_protect_decode.sv
/*
 * Protected-region decode for the four densities.
 * Assumes a stable status field and address at its inputs; purely combinational.
 */
`timescale 1ns/1ps
`include "spf_cfg.svh"

module spf_protect_decode #(
    parameter spf_pkg::spf_density_t DENSITY = 2'h3
) (
    input  wire logic        i_tb,
    input  wire logic [2:0]  i_bp,
    input  wire logic [23:0] i_addr,
    output logic             o_hit,
    output logic             o_any
);

    localparam logic [7:0] BLK_MASK = 8'((16'h2 << DENSITY) - 16'h1);

    logic       none_w;
    logic       all_w;
    logic [2:0] k_w;
    logic [7:0] blk_w;
    logic [7:0] size_w;

    // ----------------------------------------------------------------
    // code to region size (64KB blocks, as a power of two)
    // ----------------------------------------------------------------
    always_comb begin
        none_w = 1'b0;
        all_w  = 1'b0;
        k_w    = 3'h0;
        case (DENSITY)
            2'h3: begin
                none_w = (i_bp == 3'h0);
                all_w  = (i_bp >= 3'h5);
                k_w    = i_bp - 3'h1;
            end
            2'h2: begin
                none_w = (i_bp == 3'h0);
                all_w  = i_bp[2];
                k_w    = {1'b0, i_bp[1:0] - 2'h1};
            end
            2'h1: begin
                // top protect bit is ignored at this density
                none_w = (i_bp[1:0] == 2'h0);
                all_w  = (i_bp[1:0] == 2'h3);
                k_w    = {1'b0, i_bp[1:0] - 2'h1};
            end
            default: begin
                none_w = (i_bp[1:0] == 2'h0);
                all_w  = i_bp[1];
                k_w    = 3'h0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // address test: top region unless the bottom bit is set
    // ----------------------------------------------------------------
    always_comb begin
        // addresses beyond the array alias into it, as the array does
        blk_w  = i_addr[23:16] & BLK_MASK;
        size_w = 8'h1 << k_w;
        o_any  = ~none_w;
        if (none_w) begin
            o_hit = 1'b0;
        end else if (all_w) begin
            o_hit = 1'b1;
        end else if (i_tb) begin
            o_hit = (blk_w < size_w);
        end else begin
            o_hit = (blk_w >= ((BLK_MASK + 8'h1) - size_w));
        end
    end

endmodule

// File: spf_sp_assertions.sv
/*
 * Port-level checker of the serial flash status and protection block.
 * Assumes it is bound onto spf_status_protect with i_ce held high.
 */
`timescale 1ns/1ps

module spf_sp_assertions #(
    parameter int unsigned SRW_CYCLES = 4
) (
    input wire logic        i_mclk,
    input wire logic        i_rst_n,
    input wire logic        i_ce,
    input wire logic        i_sclk,
    input wire logic        i_cs_n,
    input wire logic        i_serial_in_out,
    input wire logic        i_wp_n,
    input wire logic        i_op_done,
    input wire logic        o_so,
    input wire logic        o_so_oe,
    input wire logic [7:0]  o_status_q,
    input wire logic        o_op_start,
    input wire logic [7:0]  o_op_code,
    input wire logic [23:0] o_op_addr
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    logic [15:0] busy_cnt_q;
    logic        arr_q;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || !o_status_q[0]) busy_cnt_q <= 16'h0;
        else busy_cnt_q <= busy_cnt_q + 16'h1;
    end

    // array busy ends on the engine, so it is kept apart from status-write busy
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) arr_q <= 1'b0;
        else if (o_op_start) arr_q <= 1'b1;
        else if (!o_status_q[0]) arr_q <= 1'b0;
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    chk_rsv_reads_zero: assert property (o_status_q[6] == 1'b0)
        else $error("reserved status bit set");
    chk_start_clears_wel: assert property (o_op_start |=> o_status_q[1:0] == 2'b01)
        else $error("accepted op without busy or with latch set");
    chk_start_needs_wel: assert property (o_op_start |-> $past(o_status_q[1]) && !$past(o_status_q[0]))
        else $error("op accepted without latch");
    chk_start_one_pulse: assert property (o_op_start |=> !o_op_start)
        else $error("op start longer than one cycle");
    chk_wel_set_idle: assert property ($rose(o_status_q[1]) |-> !$past(o_status_q[0]))
        else $error("latch set while busy");
    chk_fields_after_cs: assert property ($changed(o_status_q[7:2]) |-> $past(i_cs_n, 3))
        else $error("status fields changed inside a frame");
    chk_fields_need_wel: assert property ($changed(o_status_q[7:2]) |-> $past(o_status_q[1]))
        else $error("status fields changed without latch");
    chk_lock_freezes: assert property ($changed(o_status_q[7:2]) && $past(o_status_q[7])
        |-> $past(i_wp_n, 4))
        else $error("locked status written with pin low");
    chk_srw_busy_len: assert property ($fell(o_status_q[0]) && !arr_q
        |-> busy_cnt_q == 16'(SRW_CYCLES))
        else $error("status write busy length wrong");
    chk_done_ends_busy: assert property (i_op_done && arr_q && !o_op_start
        |-> ##3 !o_status_q[0])
        else $error("busy not ended by engine done");
    chk_so_quiet: assert property ($past(i_cs_n) && i_cs_n |-> !o_so_oe && !o_so)
        else $error("serial output driven while deselected");
endmodule

// File: spf_spi_host.sv
/*
 * Behavioural SPI host, mode 0, 125 ns clock that stands still between frames.
 * Assumes the caller waits for each frame task to return before the next.
 */
`timescale 1ns/1ps

module spf_spi_host (
    output logic            o_sclk,
    output logic            o_cs_n,
    output logic            o_mosi,
    input  wire logic       i_miso
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b1;
    end

    // nbits need not be a byte multiple, so short frames can be sent on purpose
    task automatic xfer(input logic [47:0] data, input int nbits, output logic [47:0] rx);
        rx = 48'h0;
        o_cs_n = 1'b0;
        for (int b = 0; b < nbits; b++) begin
            o_mosi = data[47 - b];
            #62.5 o_sclk = 1'b1;
            rx = {rx[46:0], i_miso};
            #62.5 o_sclk = 1'b0;
        end
        #62.5 o_cs_n = 1'b1;
        // released line shows the inverse, never a stale bit
        o_mosi = ~o_mosi;
        #300;
    endtask
endmodule

// File: spf_status_protect.sv
/*
 * Status register, write protection and instruction framing of a serial
 * flash, with identification read-out on the serial output.
 * Assumes an SPI host in mode 0 or 3, chip select high for at least four
 * i_mclk periods between frames, and an array engine that pulses i_op_done.
 */
`timescale 1ns/1ps
`include "spf_cfg.svh"

// Operation
// R1 - write enable sets write-enable latch
// R2 - latch cleared at reset and after writes
// R3 - protect-size bits written by status write
// R4 - protect-size bits default to zero
// R5 - lock plus low pin freezes protect-size
// R6 - bottom bit picks top or bottom region
// R7 - bottom bit default zero, needs enable
// R8 - lock plus low pin freezes bottom bit
// R9 - reserved bit always reads zero
// R10 - host masks reserved bit itself
// R11 - lock bit default zero, pin ignored
// R12 - locked: low pin rejects, high accepts
// R13 - 8 Mbit protect decode
// R14 - 4 Mbit protect decode
// R15 - 2 Mbit protect decode
// R16 - 1 Mbit protect decode
// R17 - select fall starts, opcode first, msb first
// R18 - select rise completes the instruction
// R19 - reads may end after any bit
// R20 - writes must end on byte boundary
// R21 - busy ignores all but status read
// R22 - identification bytes for three opcodes
// R23 - busy flag while writing or erasing
// R24 - status write touches writable bits only
// R25 - status write needs latch set
// R26 - protected address rejects program or erase
module spf_status_protect #(
    parameter spf_pkg::spf_density_t DENSITY    = 2'h3,
    parameter int unsigned           SRW_CYCLES = `SPF_SRW_CYCLES,
    parameter int unsigned           TMR_W      = 16,
    parameter logic [7:0]            MFR_ID     = 8'h5a,   // arbitrary value
    parameter logic [7:0]            DEV_ID8    = 8'h21,   // arbitrary value
    parameter logic [15:0]           DEV_ID16   = 16'h4321 // arbitrary value
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    input  wire logic        i_sclk,
    input  wire logic        i_cs_n,
    input  wire logic        i_serial_in_out,
    input  wire logic        i_wp_n,
    input  wire logic        i_op_done,
    output logic             o_so,
    output logic             o_so_oe,
    output logic [7:0]       o_status_q,
    output logic             o_op_start,
    output logic [7:0]       o_op_code,
    output logic [23:0]      o_op_addr
);

    // ----------------------------------------------------------------
    // link domain: bit and byte framing
    // ----------------------------------------------------------------
    logic        armed_q;
    logic [2:0]  bit_q;
    logic [2:0]  byte_q;
    logic [2:0]  lk_bit;
    logic [2:0]  lk_byte;
    logic [7:0]  in_q;
    logic [7:0]  opcode_q;
    logic [23:0] addr_q;
    logic [7:0]  st_s1_q;
    logic [7:0]  st_s2_q;
    logic        so_q;
    logic        so_oe_q;
    logic [7:0]  tx_byte;
    logic        tx_en;

    // armed marks a fresh frame; the clock may be still while select is high
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            armed_q <= 1'b1;
        end else begin
            armed_q <= 1'b0;
        end
    end

    always_comb begin
        lk_bit  = armed_q ? 3'h0 : bit_q;
        lk_byte = armed_q ? 3'h0 : byte_q;
    end

    // counters are not cleared by select so the count survives the frame end
    always_ff @(posedge i_sclk) begin
        bit_q <= lk_bit + 3'h1; // R17
        if (lk_bit == 3'h7 && lk_byte != 3'h7) begin
            byte_q <= lk_byte + 3'h1;
        end else begin
            byte_q <= lk_byte;
        end
    end

    always_ff @(posedge i_sclk) begin
        in_q <= {in_q[6:0], i_serial_in_out}; // R17
        if (lk_bit == 3'h7 && lk_byte == 3'h0) begin
            opcode_q <= {in_q[6:0], i_serial_in_out}; // R17
        end
    end

    // address or status data: the three bytes after the opcode
    always_ff @(posedge i_sclk) begin
        if (lk_byte != 3'h0 && lk_byte < `SPF_LEN_ADDR) begin
            addr_q <= {addr_q[22:0], i_serial_in_out};
        end
    end

    // status crosses bit by bit; each bit is meaningful on its own
    always_ff @(posedge i_sclk) begin
        st_s1_q <= o_status_q;
        st_s2_q <= st_s1_q;
    end

    // ----------------------------------------------------------------
    // link domain: serial output
    // ----------------------------------------------------------------
    always_comb begin
        tx_byte = 8'h00;
        tx_en   = 1'b0;
        if (!armed_q && byte_q != 3'h0) begin
            case (opcode_q)
                `SPF_OP_RDSR: begin
                    tx_byte = st_s2_q; // R19
                    tx_en   = 1'b1;
                end
                `SPF_OP_RDID8: begin
                    tx_byte = DEV_ID8; // R22
                    tx_en   = (byte_q >= `SPF_LEN_ADDR);
                end
                `SPF_OP_MFDID: begin
                    tx_byte = byte_q[0] ? DEV_ID8 : MFR_ID; // R22
                    tx_en   = (byte_q >= `SPF_LEN_ADDR);
                end
                `SPF_OP_JID: begin
                    case (byte_q)
                        3'h1:    tx_byte = MFR_ID; // R22
                        3'h2:    tx_byte = DEV_ID16[15:8];
                        default: tx_byte = DEV_ID16[7:0];
                    endcase
                    tx_en = (byte_q <= `SPF_LEN_JID);
                end
                default: begin
                    tx_byte = 8'h00;
                    tx_en   = 1'b0;
                end
            endcase
            // only the status read is answered while a cycle runs
            if (st_s2_q[`SPF_ST_BUSY] && opcode_q != `SPF_OP_RDSR) begin
                tx_en = 1'b0; // R21
            end
        end
    end

    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            so_q    <= 1'b0;
            so_oe_q <= 1'b0;
        end else begin
            so_q    <= tx_byte[3'h7 - bit_q];
            so_oe_q <= tx_en;
        end
    end

    always_comb begin
        o_so    = so_q;
        o_so_oe = so_oe_q;
    end

    // ----------------------------------------------------------------
    // core domain: pin synchronisers
    // ----------------------------------------------------------------
    logic cs_s1_q;
    logic cs_s2_q;
    logic cs_s3_q;
    logic wp_s1_q;
    logic wp_s2_q;
    logic end_evt;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            wp_s1_q <= 1'b1;
            wp_s2_q <= 1'b1;
        end else if (i_ce) begin
            cs_s1_q <= i_cs_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            wp_s1_q <= i_wp_n;
            wp_s2_q <= wp_s1_q;
        end
    end

    // link words are stable here: the frame is over and the clock is idle
    assign end_evt = cs_s2_q & ~cs_s3_q; // R18

    // ----------------------------------------------------------------
    // core domain: instruction decision
    // ----------------------------------------------------------------
    spf_pkg::spf_state_t state_q;
    logic             wel_q;
    logic             lock_q;
    logic             tb_q;
    logic [2:0]       bp_q;
    logic [TMR_W-1:0] tmr_q;
    logic             prot_hit;
    logic             prot_any;
    logic             idle_w;
    logic             whole_w;
    logic             locked_w;
    logic             is_ce;
    logic             arr_len;
    logic             arr_blk;
    logic             wren_go;
    logic             wrdi_go;
    logic             srw_go;
    logic             arr_go;

    spf_protect_decode #(
        .DENSITY (DENSITY)
    ) u_decode (
        .i_tb    (tb_q),
        .i_bp    (bp_q),
        .i_addr  (addr_q),
        .o_hit   (prot_hit), // R13 R14 R15 R16
        .o_any   (prot_any)
    );

    always_comb begin
        idle_w   = (state_q == spf_pkg::SPF_IDLE); // R21
        whole_w  = (bit_q == 3'h0); // R20
        locked_w = lock_q & ~wp_s2_q; // R11 R12
        is_ce    = (opcode_q == `SPF_OP_CE_A) || (opcode_q == `SPF_OP_CE_B);
        case (opcode_q)
            `SPF_OP_PP:   arr_len = (byte_q >= `SPF_LEN_PP);
            `SPF_OP_SE,
            `SPF_OP_BE:   arr_len = (byte_q >= `SPF_LEN_ADDR);
            `SPF_OP_CE_A,
            `SPF_OP_CE_B: arr_len = (byte_q >= `SPF_LEN_CMD);
            default:      arr_len = 1'b0;
        endcase
        // chip erase is refused if any region at all is guarded
        arr_blk = is_ce ? prot_any : prot_hit; // R26 R6
        wren_go = end_evt && idle_w && whole_w && opcode_q == `SPF_OP_WREN
                  && byte_q >= `SPF_LEN_CMD;
        wrdi_go = end_evt && idle_w && whole_w && opcode_q == `SPF_OP_WRDI
                  && byte_q >= `SPF_LEN_CMD;
        srw_go  = end_evt && idle_w && whole_w && opcode_q == `SPF_OP_WRSR
                  && byte_q == `SPF_LEN_WRSR && wel_q && !locked_w; // R25 R5 R8
        arr_go  = end_evt && idle_w && whole_w && arr_len && wel_q && !arr_blk;
    end

    // ----------------------------------------------------------------
    // core domain: busy sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state_q <= spf_pkg::SPF_IDLE;
        end else if (i_ce) begin
            case (state_q)
                spf_pkg::SPF_IDLE: begin
                    if (srw_go) begin
                        state_q <= spf_pkg::SPF_SRW; // R23
                    end else if (arr_go) begin
                        state_q <= spf_pkg::SPF_ARR; // R23
                    end
                end
                spf_pkg::SPF_SRW: begin
                    if (tmr_q == '0) begin
                        state_q <= spf_pkg::SPF_IDLE; // R23
                    end
                end
                spf_pkg::SPF_ARR: begin
                    if (i_op_done) begin
                        state_q <= spf_pkg::SPF_IDLE; // R23
                    end
                end
                default: state_q <= spf_pkg::SPF_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            tmr_q <= '0;
        end else if (i_ce) begin
            if (srw_go) begin
                tmr_q <= TMR_W'(SRW_CYCLES - 1);
            end else if (tmr_q != '0) begin
                tmr_q <= tmr_q - TMR_W'(1);
            end
        end
    end

    // ----------------------------------------------------------------
    // core domain: status fields
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            wel_q <= `SPF_RST_WEL; // R2
        end else if (i_ce) begin
            if (wren_go) begin
                wel_q <= 1'b1; // R1
            end else if (wrdi_go || srw_go || arr_go) begin
                wel_q <= 1'b0; // R2
            end
        end
    end

    // reset stands in for the factory state of the non-volatile bits
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            lock_q <= `SPF_RST_LOCK; // R11
            tb_q   <= `SPF_RST_TB; // R7
            bp_q   <= `SPF_RST_BP; // R4
        end else if (i_ce && srw_go) begin
            lock_q <= addr_q[`SPF_ST_LOCK]; // R24
            tb_q   <= addr_q[`SPF_ST_TB]; // R7
            bp_q   <= addr_q[`SPF_ST_BP_HI:`SPF_ST_BP_LO]; // R3
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_status_q <= 8'h00;
        end else if (i_ce) begin
            o_status_q[`SPF_ST_LOCK]                <= lock_q;
            o_status_q[`SPF_ST_RSV]                 <= 1'b0; // R9
            o_status_q[`SPF_ST_TB]                  <= tb_q;
            o_status_q[`SPF_ST_BP_HI:`SPF_ST_BP_LO] <= bp_q;
            o_status_q[`SPF_ST_WEL]                 <= wel_q;
            o_status_q[`SPF_ST_BUSY]                <= ~idle_w; // R23
        end
    end

    // ----------------------------------------------------------------
    // core domain: array request
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_op_start <= 1'b0;
            o_op_code  <= 8'h00;
            o_op_addr  <= 24'h000000;
        end else if (i_ce) begin
            o_op_start <= arr_go; // R26
            if (arr_go) begin
                o_op_code <= opcode_q;
                o_op_addr <= is_ce ? 24'h000000 : addr_q;
            end
        end
    end

endmodule

// File: tb_spf_status_protect.sv
/*
 * Testbench of spf_status_protect driven through the SPI host model.
 * Assumes a 100 MHz core clock and the host model in spf_spi_host.sv.
 */
`timescale 1ns/1ps

module tb_spf_status_protect;
    localparam int unsigned SRW_CYCLES = 4;
    localparam logic [7:0]  MFR        = 8'h5a;    // arbitrary value
    localparam logic [7:0]  DEV8       = 8'h21;    // arbitrary value
    localparam logic [15:0] DEV16      = 16'h4321; // arbitrary value

    logic        i_mclk    = 1'b0;
    logic        i_rst_n   = 1'b0;
    logic        i_wp_n    = 1'b1;
    logic        i_op_done = 1'b0;
    logic        sclk;
    logic        cs_n;
    logic        mosi;
    logic        o_so;
    logic        o_so_oe;
    logic [7:0]  o_status_q;
    logic        o_op_start;
    logic [7:0]  o_op_code;
    logic [23:0] o_op_addr;
    logic [47:0] rx;
    int          err_total = 0;
    int          total_checks = 0;
    int          starts = 0;
    int          s0;

    always #5 i_mclk = ~i_mclk;

    always @(posedge i_mclk) if (o_op_start === 1'b1) starts <= starts + 1;

    spf_status_protect #(.SRW_CYCLES(SRW_CYCLES), .MFR_ID(MFR), .DEV_ID8(DEV8),
        .DEV_ID16(DEV16)) spf_status_protect_i (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_serial_in_out(mosi), .i_wp_n(i_wp_n), .i_op_done(i_op_done),
        .o_so(o_so), .o_so_oe(o_so_oe), .o_status_q(o_status_q), .o_op_start(o_op_start),
        .o_op_code(o_op_code), .o_op_addr(o_op_addr));

    // data out is pulled up while not driven
    spf_spi_host spf_spi_host_i (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi),
        .i_miso(o_so_oe ? o_so : 1'b1));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic frame(input logic [7:0] op, input logic [23:0] addr, input int nbits);
        spf_spi_host_i.xfer({op, addr, 16'h0}, nbits, rx);
        @(negedge i_mclk);
    endtask

    task automatic wrsr(input logic [7:0] st);
        frame(8'h06, 24'h0, 8);
        frame(8'h01, {st, 16'h0}, 16);
        repeat (SRW_CYCLES + 10) @(negedge i_mclk);
    endtask

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // protection table: status, opcode, address, accepted
    // ----------------------------------------------------------------
    logic [7:0]  t_st[9]  = '{8'h04, 8'h04, 8'h04, 8'h24, 8'h24, 8'h10, 8'h10, 8'h14, 8'h00};
    logic [7:0]  t_op[9]  = '{8'h20, 8'hd8, 8'hc7, 8'h20, 8'h02, 8'h20, 8'h20, 8'h20, 8'h60};
    logic [23:0] t_ad[9]  = '{24'h0f1234, 24'h0effff, 24'h0, 24'h0f0000, 24'h00ff00,
                              24'h07ffff, 24'h080000, 24'h000000, 24'h0};
    logic        t_acc[9] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

    initial begin
        repeat (8) @(negedge i_mclk);
        i_rst_n = 1'b1;
        chk(o_status_q, 8'h00);
        frame(8'h05, 24'h0, 16);
        chk(rx[7:0], 8'h00);
        frame(8'h01, 24'hbc0000, 16);
        chk(o_status_q, 8'h00);
        frame(8'h06, 24'h0, 8);
        chk(o_status_q, 8'h02);
        frame(8'h01, 24'h9c0000, 15);
        chk(o_status_q, 8'h02);
        frame(8'h05, 24'h0, 12);
        chk(o_status_q, 8'h02);
        frame(8'h04, 24'h0, 8);
        chk(o_status_q, 8'h00);
        wrsr(8'hfc);
        frame(8'h05, 24'h0, 16);
        chk(rx[7:0], 8'hbc);
        chk(rx[7:0] & 8'hbf, 8'hbc);
        i_wp_n = 1'b0;
        wrsr(8'h00);
        chk(o_status_q, 8'hbe);
        i_wp_n = 1'b1;
        wrsr(8'h00);
        chk(o_status_q, 8'h00);
        for (int i = 0; i < 9; i++) begin
            wrsr(t_st[i]);
            frame(8'h06, 24'h0, 8);
            s0 = starts;
            frame(t_op[i], t_ad[i],
                  t_op[i] == 8'h02 ? 40 : ((t_op[i] == 8'hc7 || t_op[i] == 8'h60) ? 8 : 32));
            chk(starts - s0, {31'h0, t_acc[i]});
            if (t_acc[i]) begin
                chk({o_op_code, o_op_addr}, {t_op[i], t_ad[i]});
                frame(8'h06, 24'h0, 8);
                frame(8'h05, 24'h0, 16);
                chk(rx[7:0], t_st[i] | 8'h01);
                @(negedge i_mclk) i_op_done = 1'b1;
                @(negedge i_mclk) i_op_done = 1'b0;
                repeat (5) @(negedge i_mclk);
                chk(o_status_q, t_st[i]);
            end else begin
                chk(o_status_q, t_st[i] | 8'h02);
            end
        end
        frame(8'h9f, 24'h0, 32);
        chk(rx[23:0], {MFR, DEV16});
        frame(8'hab, 24'h0, 40);
        chk(rx[7:0], DEV8);
        frame(8'h90, 24'h0, 48);
        chk(rx[15:0], {MFR, DEV8});
        // a reset in mid-run must drop the latch again
        frame(8'h06, 24'h0, 8);
        chk(o_status_q, 8'h02);
        @(negedge i_mclk) i_rst_n = 1'b0;
        repeat (3) @(negedge i_mclk);
        i_rst_n = 1'b1;
        chk(o_status_q, 8'h00);
        frame(8'h06, 24'h0, 8);
        chk(o_status_q, 8'h02);
        close_out();
    end

    initial begin
        #400000;
        err_total++;
        close_out();
    end
endmodule

bind spf_status_protect spf_sp_assertions #(.SRW_CYCLES(SRW_CYCLES)) spf_sp_assertions_i (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
    .i_serial_in_out(i_serial_in_out), .i_wp_n(i_wp_n), .i_op_done(i_op_done),
    .o_so(o_so), .o_so_oe(o_so_oe), .o_status_q(o_status_q), .o_op_start(o_op_start),
    .o_op_code(o_op_code), .o_op_addr(o_op_addr));
